//--- sws_pkg.sv
`default_nettype none
package sws_pkg;
  // register port
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam logic [6:0] ADDR_STATUS = 7'h60;
  localparam logic [6:0] ADDR_FRAME_ERROR_COUNT = 7'h61;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] FRAME_ERROR_COUNT_RESET = 16'h0000;

  // status field positions
  localparam int BIT_SYNC = 6;
  localparam int BIT_PATTERN = 5;
  localparam int BIT_FRAME = 4;
  localparam int BIT_SILENCE = 3;
  localparam int BIT_ACTIVE = 2;

  // frame error counter
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_ONE = 6'h01;
  localparam logic [5:0] CNT_OVF = 6'h20;

  // transceiver mode
  localparam int MODE_W = 3;
  localparam int MODE_ENABLE_BIT = 2;
  localparam logic [2:0] MODE_NO_ACTIVATE = 3'h4;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SILENCE_US = 1000;
  localparam int SILENCE_CYCLES =
    (SILENCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SIL_W = 24;
  localparam logic [23:0] SIL_ONE = 24'h000001;
  localparam logic [23:0] SIL_ZERO = 24'h000000;
endpackage : sws_pkg
`default_nettype wire

//--- sws_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sws_pin_sync (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic pin_i,
  output logic level_o
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;
  logic level_next;

  // a change is accepted only once the last two stages agree
  always_comb begin
    level_next = level_reg;
    if (ff2_reg == ff3_reg) begin
      level_next = ff3_reg;
    end
  end

  // bus idles recessive, hence reset to one
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ff1_reg <= 1'b1;
      ff2_reg <= 1'b1;
      ff3_reg <= 1'b1;
      level_reg <= 1'b1;
    end else begin
      ff1_reg <= pin_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
endmodule : sws_pin_sync
`default_nettype wire

//--- sws_rc_flag.sv
`timescale 1ns/1ps
`default_nettype none
module sws_rc_flag (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_reg;
  logic flag_next;

  // set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    flag_next = flag_reg;
    if (clr_i) begin
      flag_next = 1'b0;
    end
    if (set_i) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_o = flag_reg;
endmodule : sws_rc_flag
`default_nettype wire

//--- sws_top.sv
// Notes on behaviour
// R1 - sync bit 6 goes high only after an error-free frame and is low while selective wake is off.
// R2 - wake-pattern bit 5 and wake-frame bit 4 set on detection and clear when the status is read.
// R3 - read-only silence bit 3 is one once the bus stayed silent longer than the silence time; the code times silence and sets it only while active.
// R4 - read-only activity bit 2 is set while active, needing system error clear, config valid and mode bit 2 set.
// R5 - selective wake activates only on a transceiver mode change, never when the new mode is 100.
// R6 - reserved bits read zero: status 15:7 and 1:0, counter register 15:6.
// R7 - the counter register shows a 6-bit error count in 5:0, zero for none, 32 for overflow.
// R8 - each frame received with an error while active adds one to the counter.
// R9 - each valid frame takes one off the counter while it is nonzero; at zero it stays.
// R10 - at 32 selective wake is disabled, system error is set and plain pattern wake is enabled.
// R11 - at overflow the counter holds until a new mode change re-enables selective wake.
`timescale 1ns/1ps
`default_nettype none
module sws_top
  import sws_pkg::*;
#(
  parameter int SIL_CYCLES_P = SILENCE_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic can_rxd_i,
  input wire logic frame_ok_i,
  input wire logic frame_err_i,
  input wire logic wake_pattern_i,
  input wire logic wake_frame_i,
  input wire logic [2:0] can_mode_i,
  input wire logic config_valid_flag_i,
  input wire logic sys_err_clr_i,
  input wire logic rd_en_i,
  input wire logic [6:0] rd_addr_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic wake_activity_flag_o,
  output logic system_error_flag_o,
  output logic can_wake_en_o
);
  localparam logic [23:0] SIL_LIMIT = SIL_CYCLES_P[23:0];

  logic rx_level;
  logic rx_prev_reg;
  logic rx_prev_next;
  logic rx_edge;
  logic [2:0] mode_prev_reg;
  logic [2:0] mode_prev_next;
  logic mode_change;
  logic act_cond;
  logic active_reg;
  logic active_next;
  logic sync_reg;
  logic sync_next;
  logic [23:0] sil_cnt_reg;
  logic [23:0] sil_cnt_next;
  logic bus_silence_flag_reg;
  logic bus_silence_flag_next;
  logic [5:0] frame_error_count_reg;
  logic [5:0] frame_error_count_next;
  logic system_error_flag_reg;
  logic system_error_flag_next;
  logic can_wake_en_reg;
  logic can_wake_en_next;
  logic [15:0] rd_data_reg;
  logic [15:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic status_read;
  logic wake_pattern_flag;
  logic wake_frame_flag;
  logic [15:0] status_word;
  logic [15:0] frame_error_count_word;

  sws_pin_sync u_rx_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .pin_i(can_rxd_i),
    .level_o(rx_level)
  );

  assign status_read = rd_en_i && (rd_addr_i == ADDR_STATUS);

  sws_rc_flag u_pattern_flag (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .set_i(wake_pattern_i), // R2
    .clr_i(status_read), // R2
    .flag_o(wake_pattern_flag)
  );

  sws_rc_flag u_frame_flag (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .set_i(wake_frame_i), // R2
    .clr_i(status_read), // R2
    .flag_o(wake_frame_flag)
  );

  assign rx_edge = rx_level != rx_prev_reg;
  assign mode_change = can_mode_i != mode_prev_reg;
  assign act_cond = !system_error_flag_reg && config_valid_flag_i
    && can_mode_i[MODE_ENABLE_BIT]; // R4

  // activation, overflow reaction and system error
  always_comb begin
    rx_prev_next = rx_level;
    mode_prev_next = can_mode_i;
    active_next = active_reg && act_cond;
    system_error_flag_next = system_error_flag_reg;
    can_wake_en_next = can_wake_en_reg;
    if (sys_err_clr_i) begin
      system_error_flag_next = 1'b0;
    end
    if (mode_change) begin
      active_next = act_cond && (can_mode_i != MODE_NO_ACTIVATE); // R5
      if (active_next) begin
        can_wake_en_next = 1'b0;
      end
    end
    // overflow wins over any activation in the same cycle
    if (active_reg && frame_error_count_reg == CNT_OVF) begin
      active_next = 1'b0; // R10
      system_error_flag_next = 1'b1; // R10
      can_wake_en_next = 1'b1; // R10
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_prev_reg <= 1'b1;
      mode_prev_reg <= 3'h0;
      active_reg <= 1'b0;
      system_error_flag_reg <= 1'b0;
      can_wake_en_reg <= 1'b0;
    end else begin
      rx_prev_reg <= rx_prev_next;
      mode_prev_reg <= mode_prev_next;
      active_reg <= active_next;
      system_error_flag_reg <= system_error_flag_next;
      can_wake_en_reg <= can_wake_en_next;
    end
  end

  // sync, silence timer and frame error counter
  always_comb begin
    sync_next = sync_reg;
    sil_cnt_next = sil_cnt_reg;
    bus_silence_flag_next = bus_silence_flag_reg;
    frame_error_count_next = frame_error_count_reg;
    if (!active_reg) begin
      sync_next = 1'b0; // R1
      sil_cnt_next = SIL_ZERO;
      bus_silence_flag_next = 1'b0;
    end else begin
      if (frame_ok_i) begin
        sync_next = 1'b1; // R1
      end
      // saturate so a long quiet bus never wraps the timer
      if (rx_edge) begin
        sil_cnt_next = SIL_ZERO;
        bus_silence_flag_next = 1'b0;
      end else if (sil_cnt_reg < SIL_LIMIT) begin
        sil_cnt_next = sil_cnt_reg + SIL_ONE;
      end else begin
        bus_silence_flag_next = 1'b1; // R3
      end
      // an error beats a valid frame reported in the same cycle
      if (frame_error_count_reg == CNT_OVF) begin
        frame_error_count_next = CNT_OVF; // R11
      end else if (frame_err_i) begin
        frame_error_count_next = frame_error_count_reg + CNT_ONE; // R8
      end else if (frame_ok_i && frame_error_count_reg != CNT_ZERO) begin
        frame_error_count_next = frame_error_count_reg - CNT_ONE; // R9
      end
    end
    // a fresh activation starts counting from zero
    if (!active_reg && active_next) begin
      frame_error_count_next = CNT_ZERO; // R11
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_reg <= 1'b0;
      sil_cnt_reg <= SIL_ZERO;
      bus_silence_flag_reg <= 1'b0;
      frame_error_count_reg <= CNT_ZERO;
    end else begin
      sync_reg <= sync_next;
      sil_cnt_reg <= sil_cnt_next;
      bus_silence_flag_reg <= bus_silence_flag_next;
      frame_error_count_reg <= frame_error_count_next;
    end
  end

  // read port
  always_comb begin
    status_word = STATUS_RESET; // R6
    status_word[BIT_SYNC] = sync_reg; // R1
    status_word[BIT_PATTERN] = wake_pattern_flag; // R2
    status_word[BIT_FRAME] = wake_frame_flag; // R2
    status_word[BIT_SILENCE] = bus_silence_flag_reg; // R3
    status_word[BIT_ACTIVE] = active_reg; // R4
    frame_error_count_word = FRAME_ERROR_COUNT_RESET; // R6
    frame_error_count_word[CNT_W-1:0] = frame_error_count_reg; // R7
  end

  always_comb begin
    rd_valid_next = rd_en_i;
    rd_data_next = 16'h0000;
    if (rd_en_i) begin
      case (rd_addr_i)
        ADDR_STATUS: begin
          rd_data_next = status_word;
        end
        ADDR_FRAME_ERROR_COUNT: begin
          rd_data_next = frame_error_count_word;
        end
        default: begin
          rd_data_next = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;
  assign wake_activity_flag_o = active_reg;
  assign system_error_flag_o = system_error_flag_reg;
  assign can_wake_en_o = can_wake_en_reg;

  // checks
  sequence seq_overflow_seen;
    active_reg && frame_error_count_reg == CNT_OVF;
  endsequence

  sequence seq_fallback;
    system_error_flag_reg && !active_reg && can_wake_en_reg;
  endsequence

  sequence seq_status_read_quiet;
    status_read && !wake_pattern_i && !wake_frame_i;
  endsequence

  AST_SYNC_OFF_WHEN_IDLE: assert property ( // R1
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !active_reg |=> !sync_reg)
    else $error("sync bit high while selective wake is off");

  AST_SYNC_NEEDS_FRAME: assert property ( // R1
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(sync_reg) |-> $past(frame_ok_i) && $past(active_reg))
    else $error("sync bit rose without a good frame");

  AST_PATTERN_SETS: assert property ( // R2
    @(posedge clk_sys_i) disable iff (!resetn_i)
    wake_pattern_i ##1 (rd_en_i && rd_addr_i == ADDR_STATUS)
    |=> rd_data_o[BIT_PATTERN])
    else $error("wake pattern not reported");

  AST_READ_CLEARS: assert property ( // R2
    @(posedge clk_sys_i) disable iff (!resetn_i)
    seq_status_read_quiet |=> !wake_pattern_flag && !wake_frame_flag)
    else $error("wake flags survived a status read");

  AST_SILENCE_ONLY_ACTIVE: assert property ( // R3
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(bus_silence_flag_reg) |-> $past(active_reg)
      && $past(sil_cnt_reg) == SIL_LIMIT && !$past(rx_edge))
    else $error("silence flag set early or while inactive");

  AST_ACTIVE_NEEDS_COND: assert property ( // R4
    @(posedge clk_sys_i) disable iff (!resetn_i)
    active_reg |-> $past(config_valid_flag_i)
      && $past(can_mode_i[MODE_ENABLE_BIT]))
    else $error("active without its enabling conditions");

  AST_NO_ACTIVATE_100: assert property ( // R5
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(active_reg) |-> $past(mode_change)
      && $past(can_mode_i) != MODE_NO_ACTIVATE)
    else $error("activation without a valid mode change");

  AST_RESERVED_ZERO: assert property ( // R6
    @(posedge clk_sys_i) disable iff (!resetn_i)
    rd_valid_o && $past(rd_addr_i) == ADDR_FRAME_ERROR_COUNT |-> rd_data_o[15:6] == 10'h000
      && rd_data_o[5:0] <= CNT_OVF)
    else $error("reserved or out-of-range counter bits read");

  AST_FRAME_ERROR_COUNT_INC: assert property ( // R8
    @(posedge clk_sys_i) disable iff (!resetn_i)
    active_reg && frame_err_i && frame_error_count_reg < CNT_OVF
      && !mode_change
    |=> frame_error_count_reg == $past(frame_error_count_reg) + CNT_ONE)
    else $error("frame error not counted");

  AST_FRAME_ERROR_COUNT_DEC: assert property ( // R9
    @(posedge clk_sys_i) disable iff (!resetn_i)
    active_reg && frame_ok_i && !frame_err_i && !mode_change
      && frame_error_count_reg != CNT_ZERO
      && frame_error_count_reg != CNT_OVF
    |=> frame_error_count_reg == $past(frame_error_count_reg) - CNT_ONE)
    else $error("valid frame did not decrement");

  AST_OVERFLOW_FALLBACK: assert property ( // R10
    @(posedge clk_sys_i) disable iff (!resetn_i)
    seq_overflow_seen ##1 !sys_err_clr_i |-> seq_fallback)
    else $error("overflow did not fall back to pattern wake");

  AST_OVERFLOW_HOLD: assert property ( // R11
    @(posedge clk_sys_i) disable iff (!resetn_i)
    frame_error_count_reg == CNT_OVF && !mode_change
    |=> frame_error_count_reg == CNT_OVF [*1])
    else $error("overflowed counter moved without a mode change");
endmodule : sws_top
`default_nettype wire

//--- sws_can_node.sv
`timescale 1ns/1ps
`default_nettype none
module sws_can_node (
  input wire logic clk_sys_i,
  output logic can_rxd_o,
  output logic frame_ok_o,
  output logic frame_err_o
);
  // bus idles recessive (high); receiver decode shows up as one-cycle pulses
  initial begin
    can_rxd_o = 1'b1;
    frame_ok_o = 1'b0;
    frame_err_o = 1'b0;
  end

  // bits held four cycles so the three-flop pin sync sees every edge
  task automatic send(input logic bad);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      #1 can_rxd_o = i[0];
      repeat (3) @(posedge clk_sys_i);
    end
    @(posedge clk_sys_i);
    #1 frame_ok_o = ~bad;
    frame_err_o = bad;
    @(posedge clk_sys_i);
    #1 frame_ok_o = 1'b0;
    frame_err_o = 1'b0;
  endtask : send
endmodule : sws_can_node
`default_nettype wire

//--- test_sws_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_sws_top;
  import sws_pkg::*;
  localparam int SIL_P = 400;
  logic clk_sys_i;
  logic resetn_i;
  logic can_rxd_i;
  logic frame_ok_i;
  logic frame_err_i;
  logic wake_pattern_i;
  logic wake_frame_i;
  logic [2:0] can_mode_i;
  logic config_valid_flag_i;
  logic sys_err_clr_i;
  logic rd_en_i;
  logic [6:0] rd_addr_i;
  logic [15:0] rd_data_o;
  logic rd_valid_o;
  logic wake_activity_flag_o;
  logic system_error_flag_o;
  logic can_wake_en_o;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;

  sws_top #(.SIL_CYCLES_P(SIL_P)) dut (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .can_rxd_i(can_rxd_i),
    .frame_ok_i(frame_ok_i),
    .frame_err_i(frame_err_i),
    .wake_pattern_i(wake_pattern_i),
    .wake_frame_i(wake_frame_i),
    .can_mode_i(can_mode_i),
    .config_valid_flag_i(config_valid_flag_i),
    .sys_err_clr_i(sys_err_clr_i),
    .rd_en_i(rd_en_i),
    .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .wake_activity_flag_o(wake_activity_flag_o),
    .system_error_flag_o(system_error_flag_o),
    .can_wake_en_o(can_wake_en_o)
  );

  sws_can_node node (
    .clk_sys_i(clk_sys_i),
    .can_rxd_o(can_rxd_i),
    .frame_ok_o(frame_ok_i),
    .frame_err_o(frame_err_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // ceiling well above the roughly 1200 cycles the sequence needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : step

  // read answer stands exactly one cycle after the request edge,
  // so it is looked at just after that edge, not one cycle later
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    rd_addr_i = a;
    rd_en_i = 1'b1;
    step(1);
    rd_en_i = 1'b0;
    chk("rd_valid", {15'h0000, rd_valid_o}, 16'h0001);
    chk("rd_data", rd_data_o, e);
    step(1);
  endtask : rd

  task automatic outs(input logic [2:0] e);
    chk("act_err_wake", {13'h0000, wake_activity_flag_o,
        system_error_flag_o, can_wake_en_o}, {13'h0000, e});
  endtask : outs

  task automatic mode(input logic [2:0] m);
    can_mode_i = m;
    step(2);
  endtask : mode

  initial begin
    resetn_i = 1'b0;
    wake_pattern_i = 1'b0;
    wake_frame_i = 1'b0;
    can_mode_i = 3'h0;
    config_valid_flag_i = 1'b0;
    sys_err_clr_i = 1'b0;
    rd_en_i = 1'b0;
    rd_addr_i = 7'h00;
    step(3);
    resetn_i = 1'b1;
    outs(3'h0);
    rd(ADDR_STATUS, STATUS_RESET);
    rd(ADDR_FRAME_ERROR_COUNT, FRAME_ERROR_COUNT_RESET);
    rd(7'h10, 16'h0000);
    config_valid_flag_i = 1'b1;
    mode(MODE_NO_ACTIVATE);
    outs(3'h0);
    mode(3'h6);
    outs(3'h4);
    rd(ADDR_STATUS, 16'h0004);
    node.send(1'b0);
    rd(ADDR_FRAME_ERROR_COUNT, 16'h0000);
    rd(ADDR_STATUS, 16'h0044);
    wake_pattern_i = 1'b1;
    wake_frame_i = 1'b1;
    step(1);
    wake_pattern_i = 1'b0;
    wake_frame_i = 1'b0;
    rd(ADDR_STATUS, 16'h0074);
    rd(ADDR_STATUS, 16'h0044);
    repeat (3) node.send(1'b1);
    rd(ADDR_FRAME_ERROR_COUNT, 16'h0003);
    node.send(1'b0);
    rd(ADDR_FRAME_ERROR_COUNT, 16'h0002);
    // quiet bus well past the silence limit
    step(SIL_P + 20);
    rd(ADDR_STATUS, 16'h004C);
    node.send(1'b0);
    rd(ADDR_STATUS, 16'h0044);
    rd(ADDR_FRAME_ERROR_COUNT, 16'h0001);
    repeat (31) node.send(1'b1);
    step(2);
    rd(ADDR_FRAME_ERROR_COUNT, {10'h000, CNT_OVF});
    outs(3'h3);
    rd(ADDR_STATUS, 16'h0000);
    node.send(1'b1);
    node.send(1'b0);
    rd(ADDR_FRAME_ERROR_COUNT, 16'h0020);
    mode(3'h5);
    outs(3'h3);
    sys_err_clr_i = 1'b1;
    step(1);
    sys_err_clr_i = 1'b0;
    step(1);
    outs(3'h1);
    mode(3'h7);
    outs(3'h4);
    rd(ADDR_FRAME_ERROR_COUNT, 16'h0000);
    config_valid_flag_i = 1'b0;
    step(2);
    outs(3'h0);
    rd(ADDR_STATUS, 16'h0000);
    end_sim();
  end
endmodule : test_sws_top
`default_nettype wire
